// file: occd_defs.svh
// offsets, field positions, reset values and timing values in ms and Hz of the current detector
`ifndef OCCD_DEFS_SVH
`define OCCD_DEFS_SVH

// =====================================================================
// register offsets (byte addresses)
`define OCCD_ADDR_HIGH_LEVEL 8'h00
`define OCCD_ADDR_HIGH_PERIOD 8'h04
`define OCCD_ADDR_LOW_LEVEL 8'h08
`define OCCD_ADDR_LOW_PERIOD 8'h0C
`define OCCD_ADDR_TERM_SEL 8'h10
`define OCCD_ADDR_STATUS 8'h14
`define OCCD_ADDR_IRQ_STS 8'h18
`define OCCD_ADDR_IRQ_MASK 8'h1C

// =====================================================================
// reset values and legal maxima (levels in 0.1 %, periods in 10 ms)
`define OCCD_RST_HIGH_LEVEL 12'h5DC
`define OCCD_MAX_HIGH_LEVEL 12'h7D0
`define OCCD_RST_HIGH_PERIOD 10'h000
`define OCCD_MAX_HIGH_PERIOD 10'h3E8
`define OCCD_RST_LOW_LEVEL 12'h032
`define OCCD_MAX_LOW_LEVEL 12'h7D0
`define OCCD_RST_LOW_PERIOD 10'h032
`define OCCD_MAX_LOW_PERIOD 10'h064
`define OCCD_RST_TERM_SEL 8'h09
`define OCCD_RATED_LEVEL 12'h3E8

// =====================================================================
// field positions
`define OCCD_STS_OC_FLAG 0
`define OCCD_STS_ZERO_FLAG 1
`define OCCD_STS_OC_ACTIVE 2
`define OCCD_STS_ZERO_ACTIVE 3
`define OCCD_STS_TERM_LSB 4
`define OCCD_IRQ_OC 0
`define OCCD_IRQ_ZERO 1
`define OCCD_SEL_NONE 2'h0
`define OCCD_SEL_OC 2'h1
`define OCCD_SEL_ZERO 2'h2

// =====================================================================
// timing: times in ms, clock in Hz, counts derived in the module
`define OCCD_CLK_HZ 32'h01312D00
`define OCCD_TICK_MS 32'h00000001
`define OCCD_PERIOD_STEP_MS 14'h000A
`define OCCD_MIN_QUAL_MS 14'h0032
`define OCCD_HIGH_FLOOR_MS 14'h0000
`define OCCD_LOW_FLOOR_MS 14'h0028
`define OCCD_HOLD_MS 7'h64

`endif

// file: occd_pkg.sv
// types shared by the current detector
package occd_pkg;

  // ===================================================================
  // detector states
  typedef enum logic [1:0] {
    OCCD_IDLE = 2'b00,
    OCCD_QUAL = 2'b01,
    OCCD_ON = 2'b10,
    OCCD_HOLD = 2'b11
  } occd_state_t;

  // ===================================================================
  // one detector's state
  typedef struct packed {
    occd_state_t st;
    logic [13:0] qual;
    logic [6:0] hold;
  } occd_det_t;

  // ===================================================================
  // register port request
  typedef struct packed {
    logic [7:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } occd_req_t;

endpackage : occd_pkg

// file: occd_detect.sv
// output current threshold detector with register port and terminal routing
//
// Summary of operation
// - overcurrent flag after sustained high current
// - levels in 0.1 % of rated current
// - high level 0..200 %, reset 150 %
// - high period 0..10 s, reset 0
// - zero high period means 50 ms
// - overcurrent flag held at least 100 ms
// - overcurrent detection active during auto tuning
// - zero flag after sustained low current
// - low level 0..200 %, reset 5 %
// - low period 0..1 s, reset 0.5 s
// - low period up to 40 ms means 50 ms
// - zero flag held 100 ms after condition
// - zero detection active during online tuning
// - flags routed to selected open collector terminals
//
// The placing of the registers and strobed register access are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "occd_defs.svh"

module occd_detect #(
  parameter int TICK_CYCLES = `OCCD_CLK_HZ / 32'd1000 * `OCCD_TICK_MS,
  parameter int TERMS = 4
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic ce,
  input wire occd_pkg::occd_req_t bus_req,
  output logic [15:0] bus_rdata,
  input wire logic [11:0] current_level,
  input wire logic drive_running,
  input wire logic tune_online,
  input wire logic tune_offline,
  input wire logic [TERMS-1:0] term_in,
  output logic [TERMS-1:0] term_out,
  output logic [TERMS-1:0] term_oe,
  output logic overcurrent_detect_flag,
  output logic zero_current_flag,
  output logic irq
);
  import occd_pkg::*;

  // ===================================================================
  // functions
  // qualification time in ms, short settings raised to the minimum
  function automatic logic [13:0] period_to_ms(
    input logic [9:0] p,
    input logic [13:0] floor_ms
  );
    logic [13:0] ms;
    ms = {4'h0, p} * `OCCD_PERIOD_STEP_MS;
    return (ms <= floor_ms) ? `OCCD_MIN_QUAL_MS : ms;
  endfunction : period_to_ms

  // write strobe aimed at one register
  function automatic logic wr_hit(
    input occd_req_t r,
    input logic [7:0] a
  );
    return r.wr && r.addr == a;
  endfunction : wr_hit

  // setting within its legal range
  function automatic logic fits(
    input logic [15:0] d,
    input logic [15:0] max
  );
    return d <= max;
  endfunction : fits

  // hold count down, stops at zero
  function automatic logic [6:0] hold_dec(
    input logic [6:0] h
  );
    return (h == 7'h00) ? 7'h00 : h - 7'h01;
  endfunction : hold_dec

  // flag selected by a terminal's routing code
  function automatic logic sel_flag(
    input logic [1:0] code,
    input logic oc_on,
    input logic zero_on
  );
    case (code)
      `OCCD_SEL_OC: return oc_on;
      `OCCD_SEL_ZERO: return zero_on;
      default: return 1'b0;
    endcase
  endfunction : sel_flag

  // status word layout
  function automatic logic [15:0] status_word(
    input logic oc_on,
    input logic zero_on,
    input logic oc_win,
    input logic zero_win,
    input logic [TERMS-1:0] lvl
  );
    logic [15:0] w;
    w = 16'h0000;
    w[`OCCD_STS_OC_FLAG] = oc_on;
    w[`OCCD_STS_ZERO_FLAG] = zero_on;
    w[`OCCD_STS_OC_ACTIVE] = oc_win;
    w[`OCCD_STS_ZERO_ACTIVE] = zero_win;
    w[`OCCD_STS_TERM_LSB +: TERMS] = lvl;
    return w;
  endfunction : status_word

  // one detector's next state
  function automatic occd_det_t det_step(
    input occd_det_t cur,
    input logic cond,
    input logic tick,
    input logic [13:0] target,
    input logic hold_from_set
  );
    occd_det_t nx;
    nx = cur;
    case (cur.st)
      OCCD_IDLE: begin
        if (cond) begin
          nx.st = OCCD_QUAL;
          nx.qual = 14'h0000;
        end
      end
      OCCD_QUAL: begin
        if (!cond) begin
          nx.st = OCCD_IDLE;
        end else if (tick) begin
          if (cur.qual >= target) begin
            nx.st = OCCD_ON;
            nx.hold = `OCCD_HOLD_MS;
          end else begin
            nx.qual = cur.qual + 14'h0001;
          end
        end
      end
      OCCD_ON: begin
        if (hold_from_set) begin
          if (tick) begin
            nx.hold = hold_dec(cur.hold);
          end
          if (!cond && cur.hold == 7'h00) begin
            nx.st = OCCD_IDLE;
          end
        end else if (!cond) begin
          nx.st = OCCD_HOLD;
          nx.hold = `OCCD_HOLD_MS;
        end
      end
      OCCD_HOLD: begin
        if (cond) begin
          nx.st = OCCD_ON;
        end else if (tick) begin
          if (cur.hold == 7'h00) begin
            nx.st = OCCD_IDLE;
          end else begin
            nx.hold = hold_dec(cur.hold);
          end
        end
      end
      default: begin
        nx.st = OCCD_IDLE;
      end
    endcase
    return nx;
  endfunction : det_step

  // ===================================================================
  // declarations
  logic [31:0] tick_cnt_r;
  logic [31:0] tick_cnt_nxt;
  logic tick;
  logic [11:0] high_level_r;
  logic [9:0] high_period_r;
  logic [11:0] low_level_r;
  logic [9:0] low_period_r;
  logic [7:0] term_sel_r;
  logic [1:0] irq_sts_r;
  logic [1:0] irq_sts_nxt;
  logic [1:0] irq_mask_r;
  logic [15:0] rdata_r;
  logic [15:0] rdata_nxt;
  occd_det_t oc_r;
  occd_det_t oc_nxt;
  occd_det_t zero_r;
  occd_det_t zero_nxt;
  logic oc_flag_r;
  logic zero_flag_r;
  logic oc_flag_nxt;
  logic zero_flag_nxt;
  logic [TERMS-1:0] term_oe_r;
  logic [TERMS-1:0] term_oe_nxt;
  logic [TERMS-1:0] term_s1_r;
  logic [TERMS-1:0] term_s2_r;
  logic [TERMS-1:0] term_s3_r;
  logic [TERMS-1:0] term_lvl_r;
  logic [TERMS-1:0] term_lvl_nxt;

  // ===================================================================
  // register decode
  wire wr_high_level = wr_hit(bus_req, `OCCD_ADDR_HIGH_LEVEL);
  wire wr_high_period = wr_hit(bus_req, `OCCD_ADDR_HIGH_PERIOD);
  wire wr_low_level = wr_hit(bus_req, `OCCD_ADDR_LOW_LEVEL);
  wire wr_low_period = wr_hit(bus_req, `OCCD_ADDR_LOW_PERIOD);
  wire wr_term_sel = wr_hit(bus_req, `OCCD_ADDR_TERM_SEL);
  wire wr_irq_sts = wr_hit(bus_req, `OCCD_ADDR_IRQ_STS);
  wire wr_irq_mask = wr_hit(bus_req, `OCCD_ADDR_IRQ_MASK);

  // out of range settings are ignored
  wire high_level_ok = fits(bus_req.wdata, {4'h0, `OCCD_MAX_HIGH_LEVEL});
  wire high_period_ok = fits(bus_req.wdata, {6'h00, `OCCD_MAX_HIGH_PERIOD});
  wire low_level_ok = fits(bus_req.wdata, {4'h0, `OCCD_MAX_LOW_LEVEL});
  wire low_period_ok = fits(bus_req.wdata, {6'h00, `OCCD_MAX_LOW_PERIOD});

  // ===================================================================
  // millisecond tick
  assign tick = tick_cnt_r == 32'(TICK_CYCLES - 1);
  assign tick_cnt_nxt = tick ? 32'h00000000 : tick_cnt_r + 32'h00000001;

  // ===================================================================
  // comparisons and detection windows
  wire oc_active = drive_running || tune_online || tune_offline;
  wire zero_active = drive_running || tune_online;
  wire oc_cond = oc_active && current_level > high_level_r;
  wire zero_cond = zero_active && current_level < low_level_r;
  wire [13:0] oc_target = period_to_ms(high_period_r, `OCCD_HIGH_FLOOR_MS);
  wire [13:0] zero_target = period_to_ms(low_period_r, `OCCD_LOW_FLOOR_MS);

  assign oc_nxt = det_step(oc_r, oc_cond, tick, oc_target, 1'b1);
  assign zero_nxt = det_step(zero_r, zero_cond, tick, zero_target, 1'b0);
  assign oc_flag_nxt = oc_nxt.st == OCCD_ON;
  assign zero_flag_nxt = zero_nxt.st == OCCD_ON || zero_nxt.st == OCCD_HOLD;

  // ===================================================================
  // terminal routing
  always_comb begin
    for (int i = 0; i < TERMS; i++) begin
      term_oe_nxt[i] = sel_flag(term_sel_r[2*(i%4) +: 2], oc_flag_nxt, zero_flag_nxt);
    end
  end

  // terminal readback: change accepted when second and third stages agree
  assign term_lvl_nxt = (~(term_s2_r ^ term_s3_r) & term_s3_r)
                      | ((term_s2_r ^ term_s3_r) & term_lvl_r);

  // ===================================================================
  // interrupt status: a new event wins over a clear
  wire [1:0] irq_ev = {zero_flag_nxt & ~zero_flag_r, oc_flag_nxt & ~oc_flag_r};
  wire [1:0] irq_clr = wr_irq_sts ? bus_req.wdata[1:0] : 2'h0;
  assign irq_sts_nxt = (irq_sts_r & ~irq_clr) | irq_ev;

  // ===================================================================
  // read mux
  always_comb begin
    rdata_nxt = 16'h0000;
    if (bus_req.rd) begin
      case (bus_req.addr)
        `OCCD_ADDR_HIGH_LEVEL: rdata_nxt = {4'h0, high_level_r};
        `OCCD_ADDR_HIGH_PERIOD: rdata_nxt = {6'h00, high_period_r};
        `OCCD_ADDR_LOW_LEVEL: rdata_nxt = {4'h0, low_level_r};
        `OCCD_ADDR_LOW_PERIOD: rdata_nxt = {6'h00, low_period_r};
        `OCCD_ADDR_TERM_SEL: rdata_nxt = {8'h00, term_sel_r};
        `OCCD_ADDR_STATUS: rdata_nxt = status_word(oc_flag_r, zero_flag_r, oc_active,
                                                   zero_active, term_lvl_r);
        `OCCD_ADDR_IRQ_STS: rdata_nxt = {14'h0000, irq_sts_r};
        `OCCD_ADDR_IRQ_MASK: rdata_nxt = {14'h0000, irq_mask_r};
        default: rdata_nxt = 16'h0000;
      endcase
    end
  end

  // ===================================================================
  // settings
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      high_level_r <= `OCCD_RST_HIGH_LEVEL;
      high_period_r <= `OCCD_RST_HIGH_PERIOD;
      low_level_r <= `OCCD_RST_LOW_LEVEL;
      low_period_r <= `OCCD_RST_LOW_PERIOD;
      term_sel_r <= `OCCD_RST_TERM_SEL;
      irq_mask_r <= 2'h0;
    end else if (ce) begin
      if (wr_high_level && high_level_ok) high_level_r <= bus_req.wdata[11:0];
      if (wr_high_period && high_period_ok) high_period_r <= bus_req.wdata[9:0];
      if (wr_low_level && low_level_ok) low_level_r <= bus_req.wdata[11:0];
      if (wr_low_period && low_period_ok) low_period_r <= bus_req.wdata[9:0];
      if (wr_term_sel) term_sel_r <= bus_req.wdata[7:0];
      if (wr_irq_mask) irq_mask_r <= bus_req.wdata[1:0];
    end
  end

  // ===================================================================
  // detectors and tick
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      tick_cnt_r <= 32'h00000000;
      oc_r <= '{st: OCCD_IDLE, qual: 14'h0000, hold: 7'h00};
      zero_r <= '{st: OCCD_IDLE, qual: 14'h0000, hold: 7'h00};
      oc_flag_r <= 1'b0;
      zero_flag_r <= 1'b0;
      term_oe_r <= '0;
    end else if (ce) begin
      tick_cnt_r <= tick_cnt_nxt;
      oc_r <= oc_nxt;
      zero_r <= zero_nxt;
      oc_flag_r <= oc_flag_nxt;
      zero_flag_r <= zero_flag_nxt;
      term_oe_r <= term_oe_nxt;
    end
  end

  // ===================================================================
  // terminal synchroniser, interrupts, read data
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      term_s1_r <= '0;
      term_s2_r <= '0;
      term_s3_r <= '0;
      term_lvl_r <= '0;
      irq_sts_r <= 2'h0;
      rdata_r <= 16'h0000;
    end else if (ce) begin
      term_s1_r <= term_in;
      term_s2_r <= term_s1_r;
      term_s3_r <= term_s2_r;
      term_lvl_r <= term_lvl_nxt;
      irq_sts_r <= irq_sts_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // ===================================================================
  // outputs: open collector pulls low while a routed flag is on
  assign term_out = '0;
  assign term_oe = term_oe_r;
  assign overcurrent_detect_flag = oc_flag_r;
  assign zero_current_flag = zero_flag_r;
  assign bus_rdata = rdata_r;
  assign irq = |(irq_sts_r & irq_mask_r);

endmodule : occd_detect

`default_nettype wire

// file: occd_detect_props.sv
// port checker for the current detector
`timescale 1ns/1ps
`default_nettype none
`include "occd_defs.svh"
module occd_detect_props #(
  parameter int TICK_CYCLES = 4,
  parameter int TERMS = 4
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic ce,
  input wire occd_pkg::occd_req_t bus_req,
  input wire logic [15:0] bus_rdata,
  input wire logic [11:0] current_level,
  input wire logic drive_running,
  input wire logic tune_online,
  input wire logic tune_offline,
  input wire logic [TERMS-1:0] term_in,
  input wire logic [TERMS-1:0] term_out,
  input wire logic [TERMS-1:0] term_oe,
  input wire logic overcurrent_detect_flag,
  input wire logic zero_current_flag,
  input wire logic irq
);
  import occd_pkg::*;
  // ==========
  // shadows and run lengths
  logic [7:0] sel_r;
  logic [1:0] mask_r;
  int oc_r, zf_r, act_r, zact_r;
  logic [TERMS-1:0] exp_oe;
  wire oc = overcurrent_detect_flag;
  wire zf = zero_current_flag;
  wire wr_ok = ce && bus_req.wr;
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      sel_r <= `OCCD_RST_TERM_SEL;
      mask_r <= 2'h0;
      oc_r <= 0;
      zf_r <= 0;
      act_r <= 0;
      zact_r <= 0;
    end else begin
      if (wr_ok && bus_req.addr == `OCCD_ADDR_TERM_SEL) sel_r <= bus_req.wdata[7:0];
      if (wr_ok && bus_req.addr == `OCCD_ADDR_IRQ_MASK) mask_r <= bus_req.wdata[1:0];
      oc_r <= oc ? oc_r + 1 : 0;
      zf_r <= zf ? zf_r + 1 : 0;
      act_r <= (drive_running | tune_online | tune_offline) ? act_r + 1 : 0;
      zact_r <= (drive_running | tune_online) ? zact_r + 1 : 0;
    end
  end
  always_comb begin
    for (int i = 0; i < TERMS; i++) begin
      exp_oe[i] = (sel_r[2*i+:2] == `OCCD_SEL_OC && oc) || (sel_r[2*i+:2] == `OCCD_SEL_ZERO && zf);
    end
  end
  default clocking dc @(posedge clock); endclocking
  default disable iff (!rst_n);
  property p_oc_qual; $rose(oc) |-> $past(act_r) >= 49 * TICK_CYCLES; endproperty
  a_oc_qual: assert property (p_oc_qual) else $error("overcurrent flag rose early");
  property p_oc_hold; $fell(oc) |-> $past(oc_r) >= 99 * TICK_CYCLES; endproperty
  a_oc_hold: assert property (p_oc_hold) else $error("overcurrent flag dropped early");
  property p_zf_qual; $rose(zf) |-> $past(zact_r) >= 49 * TICK_CYCLES; endproperty
  a_zf_qual: assert property (p_zf_qual) else $error("zero flag rose early");
  property p_zf_hold; $fell(zf) |-> $past(zf_r) >= 99 * TICK_CYCLES; endproperty
  a_zf_hold: assert property (p_zf_hold) else $error("zero flag dropped early");
  property p_route; sel_r == $past(sel_r) |-> term_oe == exp_oe; endproperty
  a_route: assert property (p_route) else $error("terminal routing wrong");
  property p_rdata; !$past(bus_req.rd) |-> bus_rdata == 16'h0000; endproperty
  a_rdata: assert property (p_rdata) else $error("read data outside answer cycle");
  property p_irq_set; $rose(oc) && mask_r[0] |-> irq; endproperty
  a_irq_set: assert property (p_irq_set) else $error("no interrupt on flag rise");
  property p_irq_mask; mask_r == 2'h0 |-> !irq; endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("masked interrupt seen");
  property p_reset; disable iff (1'b0) !rst_n |=> !oc && !zf && term_oe == '0; endproperty
  a_reset: assert property (p_reset) else $error("outputs active after reset");
  c_oc: cover property ($rose(oc));
  c_zf: cover property ($fell(zf));
  c_irq: cover property ($rose(irq));
endmodule : occd_detect_props
bind occd_detect occd_detect_props #(.TICK_CYCLES(TICK_CYCLES), .TERMS(TERMS)) u_props (
  .clock(clock), .rst_n(rst_n), .ce(ce), .bus_req(bus_req), .bus_rdata(bus_rdata),
  .current_level(current_level), .drive_running(drive_running),
  .tune_online(tune_online), .tune_offline(tune_offline), .term_in(term_in),
  .term_out(term_out), .term_oe(term_oe), .overcurrent_detect_flag(overcurrent_detect_flag),
  .zero_current_flag(zero_current_flag), .irq(irq));
`default_nettype wire

// file: occd_brake.sv
// open collector pins with pull-ups and a brake watching one of them
`timescale 1ns/1ps
`default_nettype none
module occd_brake #(
  parameter int TERMS = 4,
  parameter int BRAKE_TERM = 2
) (
  input wire logic [TERMS-1:0] term_oe,
  input wire logic [TERMS-1:0] term_out,
  output logic [TERMS-1:0] term_in,
  output logic brake_closed
);
  // ==========
  // pin high unless its transistor sinks it
  assign term_in = ~term_oe | term_out;
  assign brake_closed = !term_in[BRAKE_TERM];
endmodule : occd_brake
`default_nettype wire

// file: occd_detect_bench.sv
// self-checking bench for the current detector
`timescale 1ns/1ps
`default_nettype none
module occd_detect_bench;
  import occd_pkg::*;
  localparam int TICK = 4;
  localparam int LIMIT = 20000;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  occd_req_t req = '0;
  logic [11:0] cur = 12'h000;
  logic run = 1'b0;
  logic t_on = 1'b0;
  logic t_off = 1'b0;
  logic [15:0] rdata;
  logic [3:0] t_in, t_out, t_oe;
  logic oc, zf, irq, brake;
  int bad_count = 0;
  int checked = 0;
  int cycles = 0;
  logic [7:0] ra [8] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h18, 8'h1C, 8'h20};
  logic [15:0] rv [8] = '{16'h05DC, 16'h0000, 16'h0032, 16'h0032,
    16'h0009, 16'h0000, 16'h0000, 16'h0000};
  always #25 clock = ~clock;
  occd_detect #(.TICK_CYCLES(TICK), .TERMS(4)) dut (
    .clock(clock), .rst_n(rst_n), .ce(1'b1), .bus_req(req), .bus_rdata(rdata),
    .current_level(cur), .drive_running(run), .tune_online(t_on), .tune_offline(t_off),
    .term_in(t_in), .term_out(t_out), .term_oe(t_oe), .overcurrent_detect_flag(oc),
    .zero_current_flag(zf), .irq(irq));
  occd_brake #(.TERMS(4), .BRAKE_TERM(2)) u_brake (
    .term_oe(t_oe), .term_out(t_out), .term_in(t_in), .brake_closed(brake));
  // ==========
  // access and compare tasks
  task automatic report_and_stop();
    $display("checks %0d, mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : report_and_stop
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clock);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clock);
    req <= '0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    @(posedge clock);
    req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge clock);
    req <= '0;
    #1 chk(rdata, e);
  endtask : rd
  task automatic set(input logic [11:0] c, input logic [2:0] m);
    @(posedge clock);
    cur <= c;
    {run, t_on, t_off} <= m;
  endtask : set
  task automatic at(input int n, input logic [1:0] e);
    repeat (n * TICK) @(posedge clock);
    #1 chk({14'h0, zf, oc}, {14'h0, e});
  endtask : at
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      bad_count++;
      report_and_stop();
    end
  end
  initial begin
    repeat (16) @(posedge clock);
    rst_n <= 1'b1;
    foreach (ra[i]) rd(ra[i], rv[i]);
    wr(8'h00, 16'h07D1);
    rd(8'h00, 16'h05DC);
    wr(8'h0C, 16'h0065);
    rd(8'h0C, 16'h0032);
    wr(8'h04, 16'h03E8);
    rd(8'h04, 16'h03E8);
    wr(8'h08, 16'h07D0);
    rd(8'h08, 16'h07D0);
    wr(8'h08, 16'h0032);
    wr(8'h04, 16'h0000);
    wr(8'h1C, 16'h0001);
    wr(8'h10, 16'h0029);
    set(12'h5DC, 3'b100);
    at(60, 2'b00);
    set(12'h5DD, 3'b100);
    at(45, 2'b00);
    at(10, 2'b01);
    chk({12'h0, t_oe}, 16'h0001);
    set(12'h064, 3'b100);
    at(90, 2'b01);
    at(15, 2'b00);
    chk({15'h0, irq}, 16'h0001);
    wr(8'h18, 16'h0001);
    #1 chk({15'h0, irq}, 16'h0000);
    set(12'h5DD, 3'b100);
    at(40, 2'b00);
    set(12'h064, 3'b100);
    set(12'h5DD, 3'b100);
    at(40, 2'b00);
    at(15, 2'b01);
    set(12'h064, 3'b100);
    at(110, 2'b00);
    wr(8'h04, 16'h000A);
    set(12'h5DD, 3'b100);
    at(95, 2'b00);
    at(15, 2'b01);
    set(12'h5DD, 3'b001);
    at(110, 2'b01);
    set(12'h5DD, 3'b000);
    at(110, 2'b00);
    wr(8'h04, 16'h0000);
    set(12'h031, 3'b100);
    at(480, 2'b00);
    at(40, 2'b10);
    chk({12'h0, t_oe}, 16'h0006);
    chk({15'h0, brake}, 16'h0001);
    rd(8'h14, 16'h009E);
    set(12'h03C, 3'b100);
    at(90, 2'b10);
    at(30, 2'b00);
    wr(8'h0C, 16'h0004);
    set(12'h031, 3'b010);
    at(45, 2'b00);
    at(15, 2'b10);
    set(12'h064, 3'b000);
    at(120, 2'b00);
    rd(8'h18, 16'h0003);
    wr(8'h18, 16'h0003);
    rd(8'h18, 16'h0000);
    report_and_stop();
  end
endmodule : occd_detect_bench
`default_nettype wire
